// ==== src/voc_pkg.sv ====
// package: register map, field layout and codes of the converter channel control
// What this block does
// - channel 0 conversion trigger select at bits 6:4, resets to 1, codes 0..5.
// - channel 1 trigger select same field and reset, code 3 not offered.
// - trigger code 1: each queue write starts a conversion on that channel.
// - channel 0 refresh select at bits 9:8: none, timer, sync event, async event.
// - channel 1 refresh select at bits 9:8 with the same four codes.
// - channel 0 config bit 0: 0 continuous, 1 sample and shut-off.
// - channel 1 config bit 0: 0 continuous, 1 sample and shut-off.
// - config bit 16 keeps a sample-and-shut-off channel powered between conversions.
// - config bit 2 drive level: 0 full drive, 1 reduced drive.
// - config bits 12:11 set the queue low watermark level.
// - status bits 0 and 1 read 1 while channel 0 and 1 are enabled.
// - status bits 4 and 5 set once channel 0 and 1 have warmed up.
// - status bit 8 reads 1 while channel 0 queue is full, resets to 0.
// - command bit 10 starts sine generation, bit 11 stops it.
// - command bit 8 flushes channel 0 queue, bit 9 flushes channel 1 queue.
// - global bits 22:20 pick refresh period 2 to 256 refresh-clock cycles.
// - global bits 18:16 pick timer overflow 2 to 256 prescaled cycles.
// - each queue takes 12-bit values at bits 11:0 of its write port.
package voc_pkg;
    localparam logic [7:0] voc_off_global    = 8'h0c;
    localparam logic [7:0] voc_off_status    = 8'h10;
    localparam logic [7:0] voc_off_cfg0      = 8'h14;
    localparam logic [7:0] voc_off_cfg1      = 8'h18;
    localparam logic [7:0] voc_off_cmd       = 8'h1c;
    localparam logic [7:0] voc_off_enable    = 8'h20;
    localparam logic [7:0] voc_off_queue0    = 8'h28;
    localparam logic [7:0] voc_off_queue1    = 8'h2c;
    localparam logic [31:0] voc_cfg_mask     = 32'h0001_5b75;
    localparam logic [31:0] voc_cfg_reset    = 32'h0000_0010;
    localparam logic [31:0] voc_global_mask  = 32'h0077_0000;
    localparam int voc_conv_style_bit  = 0;
    localparam int voc_power_bit       = 2;
    localparam int voc_trig_lo         = 4;
    localparam int voc_refresh_lo      = 8;
    localparam int voc_wmark_lo        = 11;
    localparam int voc_heavy_bit       = 14;
    localparam int voc_keep_warm_bit   = 16;
    localparam int voc_timer_lo        = 16;
    localparam int voc_rperiod_lo      = 20;
    localparam int voc_cmd_flush0      = 8;
    localparam int voc_cmd_flush1      = 9;
    localparam int voc_cmd_sine_on     = 10;
    localparam int voc_cmd_sine_off    = 11;
    localparam int voc_en_on0          = 0;
    localparam int voc_en_off0         = 1;
    localparam int voc_en_on1          = 4;
    localparam int voc_en_off1         = 5;
    localparam int voc_st_en0          = 0;
    localparam int voc_st_warm0        = 4;
    localparam int voc_st_full0        = 8;
    localparam int voc_st_full1        = 9;
    localparam int voc_st_empty0       = 22;
    localparam int voc_st_sine         = 29;
    localparam int voc_data_w          = 12;
    localparam logic [3:0] voc_warm_cycles = 4'h3;
    typedef enum logic [2:0] {
        voc_trig_none, voc_trig_write, voc_trig_sync, voc_trig_sense,
        voc_trig_timer, voc_trig_async
    } voc_trig_t;
    typedef enum logic [1:0] {
        voc_ref_none, voc_ref_timer, voc_ref_sync, voc_ref_async
    } voc_ref_t;
endpackage : voc_pkg

// ==== src/voc_channel.sv ====
// one converter channel: write queue, trigger select, warm-up and power control
`timescale 1ns/100ps
`default_nettype none
module voc_channel #(
    parameter int  DEPTH     = 4,
    parameter bit  HAS_SENSE = 1'b1
) (
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        reset,
    // configuration
    input  wire logic [31:0]                 cfg,
    input  wire logic                        enable,
    input  wire logic                        flush,
    // queue write
    input  wire logic                        wr_valid,
    input  wire logic [voc_pkg::voc_data_w-1:0] wr_data,
    // trigger sources
    input  wire logic                        sync_event,
    input  wire logic                        async_event,
    input  wire logic                        sense_event,
    input  wire logic                        timer_tick,
    input  wire logic                        refresh_tick,
    // state out
    output logic                             conv_pulse,
    output logic [voc_pkg::voc_data_w-1:0]   conv_value,
    output logic                             powered,
    output logic                             warm,
    output logic                             full,
    output logic                             empty,
    output logic                             below_mark
);
    import voc_pkg::*;
    localparam int AW = $clog2(DEPTH);
    initial if (DEPTH < 2 || DEPTH > 8 || (1 << AW) != DEPTH)
        $error("voc_channel: DEPTH must be a power of two from 2 to 8");

    logic [voc_data_w-1:0] mem_q [DEPTH];
    logic [voc_data_w-1:0] mem_d [DEPTH];
    logic [AW-1:0] rd_q, rd_d, wr_q, wr_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic [3:0]    warm_cnt_q, warm_cnt_d;
    logic          warm_q, warm_d;
    logic [voc_data_w-1:0] value_q, value_d;
    logic          conv_q, conv_d;
    logic          trig, refresh, fire, push;
    voc_trig_t     tsel;
    voc_ref_t      rsel;

    always_comb begin
        tsel = voc_trig_t'(cfg[voc_trig_lo +: 3]);
        rsel = voc_ref_t'(cfg[voc_refresh_lo +: 2]);
        push = wr_valid && (cnt_q != (AW+1)'(DEPTH)) && !flush;
        case (tsel)
            voc_trig_write: trig = wr_valid;
            voc_trig_sync:  trig = sync_event;
            voc_trig_sense: trig = HAS_SENSE ? sense_event : 1'b0;
            voc_trig_timer: trig = timer_tick;
            voc_trig_async: trig = async_event;
            default:        trig = 1'b0;
        endcase
        case (rsel)
            voc_ref_timer: refresh = refresh_tick;
            voc_ref_sync:  refresh = sync_event;
            voc_ref_async: refresh = async_event;
            default:       refresh = 1'b0;
        endcase
        // a triggered conversion pops the queue, a refresh-only one does not; a write trigger may convert the word just pushed
        fire = enable && warm_q && (trig || refresh) && (cnt_q != '0 || push);
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        value_d = value_q;
        if (push) begin
            mem_d[wr_q] = wr_data;
            wr_d = wr_q + 1'b1;
            cnt_d = cnt_d + 1'b1;
        end
        if (fire && trig) begin
            value_d = (cnt_q != '0) ? mem_q[rd_q] : wr_data;
            rd_d = rd_q + 1'b1;
            cnt_d = cnt_d - 1'b1;
        end
        if (flush) begin
            rd_d = '0;
            wr_d = '0;
            cnt_d = '0;
        end
        conv_d = fire;
        warm_d = warm_q;
        warm_cnt_d = warm_cnt_q;
        if (!enable) begin
            warm_d = 1'b0;
            warm_cnt_d = '0;
        end else if (!warm_q) begin
            warm_cnt_d = warm_cnt_q + 1'b1;
            warm_d = (warm_cnt_q == voc_warm_cycles);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rd_q <= '0;
            wr_q <= '0;
            cnt_q <= '0;
            warm_q <= 1'b0;
            warm_cnt_q <= '0;
            value_q <= '0;
            conv_q <= 1'b0;
            for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
        end else begin
            rd_q <= rd_d;
            wr_q <= wr_d;
            cnt_q <= cnt_d;
            warm_q <= warm_d;
            warm_cnt_q <= warm_cnt_d;
            value_q <= value_d;
            conv_q <= conv_d;
            mem_q <= mem_d;
        end
    end

    always_comb begin
        conv_pulse = conv_q;
        conv_value = value_q;
        warm = warm_q;
        full = (cnt_q == (AW+1)'(DEPTH));
        empty = (cnt_q == '0);
        below_mark = (cnt_q <= (AW+1)'(cfg[voc_wmark_lo +: 2]));
        // continuous keeps power; sample-off powers down unless keep-warm
        powered = enable && (!cfg[voc_conv_style_bit]
                  || cfg[voc_keep_warm_bit] || conv_q);
    end
endmodule : voc_channel
`default_nettype wire

// ==== src/voc_top.sv ====
// ahb-lite register slave and global timers of the two-channel converter control
`timescale 1ns/100ps
`default_nettype none
module voc_top #(
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // event inputs
    input  wire logic        synchronous_event_input,
    input  wire logic        asynchronous_event_input,
    input  wire logic        sense_trigger,
    input  wire logic        refresh_clock_tick,
    input  wire logic        prescaled_clock_tick,
    // converter controls
    output logic [1:0]       conv_start,
    output logic [23:0]      conv_data,
    output logic [1:0]       chan_powered,
    output logic [1:0]       reduced_drive_level,
    output logic [1:0]       heavy_load_drive_enable,
    output logic             sine_active
);
    import voc_pkg::*;

    logic [31:0] cfg_q [2];
    logic [31:0] cfg_d [2];
    logic [31:0] glb_q, glb_d;
    logic [1:0]  en_q, en_d;
    logic        sine_q, sine_d;
    logic        ph_q, ph_d, wr_q, wr_d;
    logic [7:0]  adr_q, adr_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0]  tmr_q, tmr_d, rtmr_q, rtmr_d;
    logic        tmr_tick_q, tmr_tick_d, rtmr_tick_q, rtmr_tick_d;
    logic [1:0]  qwr, flush, cpulse, pwr, warm, full, empty, mark;
    logic [voc_data_w-1:0] cval [2];
    logic [1:0]  out_start_q;
    logic [23:0] out_data_q;
    logic [1:0]  out_pwr_q, out_low_q, out_heavy_q;
    logic        wr_go;

    always_comb begin
        ph_d = hsel && hready && htrans[1];
        wr_d = hwrite;
        adr_d = haddr;
        wr_go = ph_q && wr_q;
        cfg_d = cfg_q;
        glb_d = glb_q;
        en_d = en_q;
        sine_d = sine_q;
        qwr = '0;
        flush = '0;
        if (wr_go) begin
            if (adr_q == voc_off_cfg0) begin
                cfg_d[0] = hwdata & voc_cfg_mask;
            end else if (adr_q == voc_off_cfg1) begin
                cfg_d[1] = hwdata & voc_cfg_mask;
                // code 3 is not offered on channel 1; fold it to none
                if (hwdata[voc_trig_lo +: 3] == 3'h3)
                    cfg_d[1][voc_trig_lo +: 3] = 3'h0;
            end else if (adr_q == voc_off_global) begin
                glb_d = hwdata & voc_global_mask;
            end else if (adr_q == voc_off_cmd) begin
                flush[0] = hwdata[voc_cmd_flush0];
                flush[1] = hwdata[voc_cmd_flush1];
                if (hwdata[voc_cmd_sine_on]) sine_d = 1'b1;
                if (hwdata[voc_cmd_sine_off]) sine_d = 1'b0;
            end else if (adr_q == voc_off_enable) begin
                if (hwdata[voc_en_on0]) en_d[0] = 1'b1;
                if (hwdata[voc_en_off0]) en_d[0] = 1'b0;
                if (hwdata[voc_en_on1]) en_d[1] = 1'b1;
                if (hwdata[voc_en_off1]) en_d[1] = 1'b0;
            end else if (adr_q == voc_off_queue0) begin
                qwr[0] = 1'b1;
            end else if (adr_q == voc_off_queue1) begin
                qwr[1] = 1'b1;
            end
        end
        rdata_d = '0;
        if (ph_d && !hwrite) begin
            if (haddr == voc_off_cfg0) begin
                rdata_d = cfg_d[0];
            end else if (haddr == voc_off_cfg1) begin
                rdata_d = cfg_d[1];
            end else if (haddr == voc_off_global) begin
                rdata_d = glb_d;
            end else if (haddr == voc_off_status) begin
                rdata_d[voc_st_en0 +: 2] = en_q;
                rdata_d[voc_st_warm0 +: 2] = warm;
                rdata_d[voc_st_full0] = full[0];
                rdata_d[voc_st_full1] = full[1];
                rdata_d[voc_st_empty0 +: 2] = empty;
                rdata_d[voc_st_sine] = sine_q;
            end
        end
        // free-running dividers: overflow once per 2^(sel+1) ticks
        tmr_d = prescaled_clock_tick ? tmr_q + 1'b1 : tmr_q;
        tmr_tick_d = prescaled_clock_tick &&
            (tmr_q[3'(glb_q[voc_timer_lo +: 3]) - 3'h0 +: 1] == 1'b1) &&
            ((tmr_q & ((8'h2 << glb_q[voc_timer_lo +: 3]) - 8'h1))
             == ((8'h2 << glb_q[voc_timer_lo +: 3]) - 8'h1));
        rtmr_d = refresh_clock_tick ? rtmr_q + 1'b1 : rtmr_q;
        rtmr_tick_d = refresh_clock_tick &&
            ((rtmr_q & ((8'h2 << glb_q[voc_rperiod_lo +: 3]) - 8'h1))
             == ((8'h2 << glb_q[voc_rperiod_lo +: 3]) - 8'h1));
    end

    for (genvar c = 0; c < 2; c++) begin : g_chan
        voc_channel #(.DEPTH(DEPTH), .HAS_SENSE(c == 0)) u_chan (
            .clock        (clock),
            .reset        (reset),
            .cfg          (cfg_q[c]),
            .enable       (en_q[c]),
            .flush        (flush[c]),
            .wr_valid     (qwr[c]),
            .wr_data      (hwdata[voc_data_w-1:0]),
            .sync_event   (synchronous_event_input),
            .async_event  (asynchronous_event_input),
            .sense_event  (sense_trigger),
            .timer_tick   (tmr_tick_q),
            .refresh_tick (rtmr_tick_q),
            .conv_pulse   (cpulse[c]),
            .conv_value   (cval[c]),
            .powered      (pwr[c]),
            .warm         (warm[c]),
            .full         (full[c]),
            .empty        (empty[c]),
            .below_mark   (mark[c])
        );
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            cfg_q[0] <= voc_cfg_reset;
            cfg_q[1] <= voc_cfg_reset;
            glb_q <= '0;
            en_q <= '0;
            sine_q <= 1'b0;
            ph_q <= 1'b0;
            wr_q <= 1'b0;
            adr_q <= '0;
            rdata_q <= '0;
            tmr_q <= '0;
            rtmr_q <= '0;
            tmr_tick_q <= 1'b0;
            rtmr_tick_q <= 1'b0;
            out_start_q <= '0;
            out_data_q <= '0;
            out_pwr_q <= '0;
            out_low_q <= '0;
            out_heavy_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            glb_q <= glb_d;
            en_q <= en_d;
            sine_q <= sine_d;
            ph_q <= ph_d;
            wr_q <= wr_d;
            adr_q <= adr_d;
            rdata_q <= rdata_d;
            tmr_q <= tmr_d;
            rtmr_q <= rtmr_d;
            tmr_tick_q <= tmr_tick_d;
            rtmr_tick_q <= rtmr_tick_d;
            out_start_q <= cpulse;
            out_data_q <= {cval[1], cval[0]};
            out_pwr_q <= pwr;
            out_low_q <= {cfg_q[1][voc_power_bit], cfg_q[0][voc_power_bit]};
            // heavy drive is held off under reduced drive level
            out_heavy_q <= {cfg_q[1][voc_heavy_bit] & ~cfg_q[1][voc_power_bit],
                            cfg_q[0][voc_heavy_bit] & ~cfg_q[0][voc_power_bit]};
        end
    end

    always_comb begin
        hrdata = rdata_q;
        hreadyout = 1'b1;
        hresp = 1'b0;
        conv_start = out_start_q;
        conv_data = out_data_q;
        chan_powered = out_pwr_q;
        reduced_drive_level = out_low_q;
        heavy_load_drive_enable = out_heavy_q;
        sine_active = sine_q;
    end
endmodule : voc_top
`default_nettype wire

// ==== sim/voc_event_model.sv ====
// model of the event sources and clock-enable ticks that feed the control block
`timescale 1ns/100ps
`default_nettype none
module voc_event_model #(
    parameter int PRESC_DIV   = 2,
    parameter int REFRESH_DIV = 4
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // event requests from the bench: bit0 sync, bit1 async, bit2 sense
    input  wire logic [2:0] fire,
    // event and tick outputs
    output logic            sync_evt,
    output logic            async_evt,
    output logic            sense_evt,
    output logic            presc_tick,
    output logic            refresh_tick
);
    int presc_cnt;
    int refresh_cnt;
    // events launch from the converter clock, so the sync source shares its clock group
    always_ff @(posedge clock) begin
        if (reset) begin
            sync_evt <= 1'b0;
            async_evt <= 1'b0;
            sense_evt <= 1'b0;
            presc_tick <= 1'b0;
            refresh_tick <= 1'b0;
            presc_cnt <= 0;
            refresh_cnt <= 0;
        end else begin
            sync_evt <= fire[0];
            async_evt <= fire[1];
            sense_evt <= fire[2];
            presc_cnt <= (presc_cnt == PRESC_DIV - 1) ? 0 : presc_cnt + 1;
            presc_tick <= (presc_cnt == PRESC_DIV - 1);
            refresh_cnt <= (refresh_cnt == REFRESH_DIV - 1) ? 0 : refresh_cnt + 1;
            refresh_tick <= (refresh_cnt == REFRESH_DIV - 1);
        end
    end
endmodule : voc_event_model
`default_nettype wire

// ==== sim/voc_top_assertions.sv ====
// checker: timing properties on the converter control top-level ports
`timescale 1ns/100ps
`default_nettype none
module voc_top_assertions (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // bus
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    // converter controls
    input  wire logic [1:0]  conv_start,
    input  wire logic [23:0] conv_data,
    input  wire logic [1:0]  chan_powered,
    input  wire logic [1:0]  reduced_drive_level,
    input  wire logic [1:0]  heavy_load_drive_enable,
    input  wire logic        sine_active
);
    import voc_pkg::*;
    logic cmd_q;
    logic cmd_d;
    // command data phase follows its address phase by one cycle
    always_comb begin
        cmd_d = hsel && hready && htrans[1] && hwrite && (haddr == voc_off_cmd);
    end
    always_ff @(posedge clock) begin
        cmd_q <= reset ? 1'b0 : cmd_d;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    property p_sine_on;
        cmd_q && hwdata[voc_cmd_sine_on] && !hwdata[voc_cmd_sine_off] |-> ##[1:3] sine_active;
    endproperty
    a_sine_on: assert property (p_sine_on) else $error("sine did not start");
    property p_sine_off;
        cmd_q && hwdata[voc_cmd_sine_off] && !hwdata[voc_cmd_sine_on] |-> ##[1:3] !sine_active;
    endproperty
    a_sine_off: assert property (p_sine_off) else $error("sine did not stop");
    property p_cmd_zero;
        cmd_q && (hwdata[11:10] == 2'b00) |-> ##1 $stable(sine_active) [*3];
    endproperty
    a_cmd_zero: assert property (p_cmd_zero) else $error("zero command moved sine");
    property p_heavy0;
        heavy_load_drive_enable[0] |-> !reduced_drive_level[0];
    endproperty
    a_heavy0: assert property (p_heavy0) else $error("heavy drive at low level ch0");
    property p_heavy1;
        heavy_load_drive_enable[1] |-> !reduced_drive_level[1];
    endproperty
    a_heavy1: assert property (p_heavy1) else $error("heavy drive at low level ch1");
    property p_reset_out;
        $fell(reset) |-> conv_start == 2'b00 && !sine_active && chan_powered == 2'b00;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not clear");
    property p_data0;
        !$past(reset) && $changed(conv_data[11:0]) |-> conv_start[0] || $past(conv_start[0]);
    endproperty
    a_data0: assert property (p_data0) else $error("ch0 data moved alone");
    property p_data1;
        !$past(reset) && $changed(conv_data[23:12]) |-> conv_start[1] || $past(conv_start[1]);
    endproperty
    a_data1: assert property (p_data1) else $error("ch1 data moved alone");
endmodule : voc_top_assertions
bind voc_top voc_top_assertions i_chk (.clock(clock), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .conv_start(conv_start), .conv_data(conv_data), .chan_powered(chan_powered),
    .reduced_drive_level(reduced_drive_level),
    .heavy_load_drive_enable(heavy_load_drive_enable), .sine_active(sine_active));
`default_nettype wire

// ==== sim/voc_top_tb_top.sv ====
// self-checking bench of the converter channel control
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin failures++; \
    $display("FAIL %s expected %h seen %h", nm, ex, gt); end end
module voc_top_tb_top;
    import voc_pkg::*;
    logic        clock = 0;
    logic        reset = 1;
    logic        hsel = 0;
    logic [7:0]  haddr = 0;
    logic [1:0]  htrans = 0;
    logic        hwrite = 0;
    logic [31:0] hwdata = 0;
    logic [31:0] hrdata, rv;
    logic        hreadyout, hresp, sev, aev, tev, ptk, rtk, sine;
    logic [2:0]  fire = 0;
    logic [1:0]  cs, pw, rdl, hld;
    logic [23:0] cd;
    int          failures = 0, num_checks = 0, n0 = 0, n1 = 0;
    voc_top #(.DEPTH(4)) i_dut (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .synchronous_event_input(sev), .asynchronous_event_input(aev), .sense_trigger(tev),
        .refresh_clock_tick(rtk), .prescaled_clock_tick(ptk), .conv_start(cs),
        .conv_data(cd), .chan_powered(pw), .reduced_drive_level(rdl),
        .heavy_load_drive_enable(hld), .sine_active(sine));
    voc_event_model #(.PRESC_DIV(2), .REFRESH_DIV(4)) i_src (.clock(clock), .reset(reset),
        .fire(fire), .sync_evt(sev), .async_evt(aev), .sense_evt(tev), .presc_tick(ptk),
        .refresh_tick(rtk));
    initial begin
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        if (cs[0] === 1'b1) n0++;
        if (cs[1] === 1'b1) n1++;
    end
    // one single word transfer; read data lands in rv at the data-phase edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask : xfer
    task automatic wait_go(input int ch, input int was);
        int k;
        k = 0;
        while (((ch == 0) ? n0 : n1) == was && k < 60) begin
            @(posedge clock);
            k++;
        end
    endtask : wait_go
    task automatic t_reset();
        xfer(voc_off_cfg0, 0, 0);
        `CHK("cfg0", voc_cfg_reset, rv)
        xfer(voc_off_cfg1, 0, 0);
        `CHK("cfg1", voc_cfg_reset, rv)
        xfer(voc_off_status, 0, 0);
        `CHK("st", 5'h00, {rv[voc_st_full0], rv[5:4], rv[1:0]})
        xfer(8'h3c, 0, 0);
        `CHK("hole", 32'h0, rv)
        `CHK("resp", 1'b0, hresp)
    endtask : t_reset
    task automatic t_fields();
        xfer(voc_off_cfg0, 1, 32'h0001_5b55);
        xfer(voc_off_cfg0, 0, 0);
        `CHK("cfg0", 32'h0001_5b55, rv)
        `CHK("low", 2'b01, {hld[0], rdl[0]})
        xfer(voc_off_cfg1, 1, 32'h0000_4000);
        repeat (2) @(posedge clock);
        `CHK("heavy", 2'b10, {hld[1], rdl[1]})
        for (int c = 0; c < 6; c++) begin
            xfer(voc_off_cfg1, 1, (32'(c) << 4) | (32'(c % 4) << 8));
            xfer(voc_off_cfg1, 0, 0);
            `CHK("trig1", (c == 3) ? 3'h0 : 3'(c), rv[6:4])
            `CHK("ref1", 2'(c % 4), rv[9:8])
            xfer(voc_off_cfg0, 1, (32'(c) << 4) | (32'(c % 4) << 8));
            xfer(voc_off_cfg0, 0, 0);
            `CHK("trig0", 3'(c), rv[6:4])
            `CHK("ref0", 2'(c % 4), rv[9:8])
        end
    endtask : t_fields
    task automatic t_soft();
        int n;
        xfer(voc_off_enable, 1, 32'h0000_0011);
        repeat (8) @(posedge clock);
        xfer(voc_off_status, 0, 0);
        `CHK("on", 4'hf, {rv[5:4], rv[1:0]})
        xfer(voc_off_cfg0, 1, 32'h0000_0011);
        xfer(voc_off_cfg1, 1, 32'h0000_0010);
        n = n0;
        xfer(voc_off_queue0, 1, 32'hfff0_0abc);
        wait_go(0, n);
        `CHK("sw0", 12'habc, (n0 > n) ? cd[11:0] : 12'h0)
        n = n1;
        xfer(voc_off_queue1, 1, 32'h0000_0123);
        wait_go(1, n);
        `CHK("sw1", 12'h123, (n1 > n) ? cd[23:12] : 12'h0)
        repeat (10) @(posedge clock);
        `CHK("pwr", 2'b10, pw)
        xfer(voc_off_cfg0, 1, 32'h0001_0011);
        xfer(voc_off_queue0, 1, 32'h0000_0001);
        repeat (10) @(posedge clock);
        `CHK("keep", 1'b1, pw[0])
        xfer(voc_off_enable, 1, 32'h0000_0002);
        xfer(voc_off_status, 0, 0);
        `CHK("dis", 1'b0, rv[voc_st_en0])
        xfer(voc_off_enable, 1, 32'h0000_0001);
        repeat (8) @(posedge clock);
    endtask : t_soft
    task automatic t_full();
        xfer(voc_off_cfg0, 1, 32'h0);
        xfer(voc_off_cfg1, 1, 32'h0);
        for (int i = 0; i < 5; i++) begin
            xfer(voc_off_queue0, 1, 32'(i));
            xfer(voc_off_queue1, 1, 32'(i));
        end
        xfer(voc_off_status, 0, 0);
        `CHK("full", 2'b11, {rv[voc_st_full1], rv[voc_st_full0]})
        xfer(voc_off_cmd, 1, 32'h0000_0100);
        xfer(voc_off_status, 0, 0);
        `CHK("fl0", 3'b110, {rv[voc_st_empty0], rv[voc_st_full1], rv[voc_st_full0]})
        xfer(voc_off_cmd, 1, 32'h0000_0200);
        xfer(voc_off_status, 0, 0);
        `CHK("fl1", 2'b10, {rv[voc_st_empty0 + 1], rv[voc_st_full1]})
    endtask : t_full
    task automatic t_sine();
        xfer(voc_off_cmd, 1, 32'h0000_0400);
        xfer(voc_off_status, 0, 0);
        `CHK("sine_on", 2'b11, {rv[voc_st_sine], sine})
        xfer(voc_off_cmd, 1, 32'h0);
        repeat (2) @(posedge clock);
        `CHK("sine_hold", 1'b1, sine)
        xfer(voc_off_cmd, 1, 32'h0000_0800);
        repeat (2) @(posedge clock);
        `CHK("sine_off", 1'b0, sine)
    endtask : t_sine
    // sync, async, sense and timer triggers; the bench fires the event pins
    task automatic t_events();
        logic [2:0] code [4];
        logic [2:0] fb [4];
        int n;
        code = '{3'h2, 3'h5, 3'h3, 3'h4};
        fb = '{3'h1, 3'h2, 3'h4, 3'h0};
        for (int i = 0; i < 4; i++) begin
            xfer(voc_off_cfg0, 1, {25'h0, code[i], 4'h0});
            n = n0;
            xfer(voc_off_queue0, 1, 32'h0000_0a50 + 32'(i));
            if (fb[i] != 3'h0) begin
                repeat (6) @(posedge clock);
                `CHK("idle0", n, n0)
                fire <= fb[i];
                @(posedge clock);
                fire <= 3'h0;
            end
            wait_go(0, n);
            `CHK("evt0", 12'ha50 + 12'(i), (n0 > n) ? cd[11:0] : 12'h0)
        end
        xfer(voc_off_cfg0, 1, 32'h0000_0100);
        n = n0;
        // refresh needs a queued word; with no trigger selected nothing pops it
        xfer(voc_off_queue0, 1, 32'h0000_0a5f);
        wait_go(0, n);
        `CHK("refresh0", 1'b1, n0 > n)
        `CHK("refresh_val", 12'ha53, cd[11:0])
    endtask : t_events
    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (30000) @(posedge clock);
        failures++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_fields();
        t_soft();
        t_full();
        t_sine();
        t_events();
        complete_run();
    end
endmodule : voc_top_tb_top
`default_nettype wire
